// [hw/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync import spdif_config_pkg::*; #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// Asynchronous level and its filtered copy
	input  wire logic [WIDTH-1:0] pin_in,
	output      logic [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;

	if (WIDTH < 1) begin : width_check
		$error("pin_sync needs at least one bit");
	end

	// Three-stage chain; only stage two reads stage one
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
		end else begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			level_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_reg[i] == stage3_reg[i]) begin
					level_out[i] <= stage3_reg[i];
				end
			end
		end
	end

endmodule

// [hw/rx_sample_queue.sv]
`timescale 1ns/10ps
module rx_sample_queue import spdif_config_pkg::*; #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 6
) (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     reset_n,
	// Control
	input  wire logic                     disable_in,
	input  wire logic                     keep_one,
	// Fill side
	input  wire logic                     push,
	input  wire logic [WIDTH-1:0]         push_data,
	// Drain side
	input  wire logic                     pop,
	output      logic [WIDTH-1:0]         head_reg,
	output      logic [$clog2(DEPTH+1)-1:0] count_reg
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic             do_push;
	logic             do_pop;

	if (DEPTH < 6) begin : depth_check
		$error("rx_sample_queue needs room for six samples");
	end

	// Wrap a pointer at the queue depth
	function automatic logic [PW-1:0] step(input logic [PW-1:0] ptr);
		return (ptr == PW'(DEPTH - 1)) ? '0 : ptr + PW'(1);
	endfunction

	// Switched-off queue takes nothing from the line side
	assign do_push = push && !disable_in && (count_reg != ($clog2(DEPTH+1))'(DEPTH)) && !keep_one;
	assign do_pop  = pop && (count_reg != '0) && !keep_one;

	// Sample storage
	always_ff @(posedge clock) begin
		if (do_push) begin
			mem[wr_ptr_reg] <= push_data;
		end
	end

	// Head word comes out of a register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			head_reg <= '0;
		end else begin
			head_reg <= mem[rd_ptr_reg];
		end
	end

	// Pointers and fill count; reset holds one sample back
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (keep_one) begin
			if (count_reg > 1) begin
				rd_ptr_reg <= (wr_ptr_reg == '0) ? PW'(DEPTH - 1) : wr_ptr_reg - PW'(1);
				count_reg  <= ($clog2(DEPTH+1))'(1);
			end
		end else begin
			if (do_push) begin
				wr_ptr_reg <= step(wr_ptr_reg);
			end
			if (do_pop) begin
				rd_ptr_reg <= step(rd_ptr_reg);
			end
			if (do_push && !do_pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (do_pop && !do_push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule

// [hw/spdif_config_pkg.sv]
// Function
// - Force bit makes receive data reads zero
// - Disabled receive queue accepts no samples
// - Queue reset leaves one sample remaining
// - Full threshold codes mean 1,2,3,6 samples
// - Bit 18 enables receive auto resync
// - Bit 17 enables transmit auto resync
// - Transmit control: zero, normal, reset, reserved
// - Receive DMA request when queue full
// - Transmit DMA request when transmit empty
// - Validity set when bit clear, cleared otherwise
// - Output source: off, feed-through, normal
// - User bits: none, receiver, transmitter
// - Subcode mode bit selects CD subcode
// - CD control bits 23-15, 7-3 read zero
// - Clock select with lock fallback codes
// - Lock bit read only, follows loop
// - Phase register reserved bits read zero
package spdif_config_pkg;

	// ************************************************************
	// Register indices; byte address is four times the index
	// ************************************************************
	localparam logic [23:0] CONFIG_INDEX    = 24'hFF_FF60;
	localparam logic [23:0] CD_TEXT_INDEX   = 24'hFF_FF61;
	localparam logic [23:0] PHASE_INDEX     = 24'hFF_FF62;
	localparam logic [23:0] RX_LEFT_INDEX   = 24'hFF_FF65;
	localparam logic [23:0] RX_RIGHT_INDEX  = 24'hFF_FF66;
	localparam logic [23:0] INT_STAT_INDEX  = 24'hFF_FF78;
	localparam logic [23:0] INT_MASK_INDEX  = 24'hFF_FF79;

	// ************************************************************
	// Reset values and writable masks
	// ************************************************************
	localparam logic [23:0] CONFIG_RESET    = 24'h00_0400;
	localparam logic [23:0] CD_TEXT_RESET   = 24'h00_0000;
	localparam logic [23:0] PHASE_RESET     = 24'h00_0000;
	localparam logic [23:0] CONFIG_WMASK    = 24'hFE_0F3F;
	localparam logic [23:0] CD_TEXT_WMASK   = 24'h00_0002;
	localparam logic [23:0] PHASE_WMASK     = 24'h00_07B8;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int RD_ZERO_BIT   = 23;
	localparam int RXQ_DIS_BIT   = 22;
	localparam int RXQ_RST_BIT   = 21;
	localparam int RX_THR_LSB    = 19;
	localparam int RX_RESYNC_BIT = 18;
	localparam int TX_RESYNC_BIT = 17;
	localparam int TXQ_CTRL_LSB  = 10;
	localparam int DMA_RX_BIT    = 9;
	localparam int DMA_TX_BIT    = 8;
	localparam int RX_SEL_LSB    = 6;
	localparam int VALIDITY_BIT  = 5;
	localparam int TX_SRC_LSB    = 2;
	localparam int USER_SRC_LSB  = 0;
	localparam int SUBCODE_BIT   = 1;
	localparam int CLK_SRC_LSB   = 7;
	localparam int LOCK_BIT      = 6;
	localparam int GAIN_LSB      = 3;

	// Interrupt status bit positions
	localparam int IRQ_RX_FULL   = 0;
	localparam int IRQ_TX_EMPTY  = 1;
	localparam int IRQ_LOCK_GAIN = 2;
	localparam int IRQ_LOCK_LOSS = 3;
	localparam int IRQ_WIDTH     = 4;

	// ************************************************************
	// Field codes
	// ************************************************************
	localparam logic [1:0] TXQ_ZERO       = 2'h0;
	localparam logic [1:0] TXQ_NORMAL     = 2'h1;
	localparam logic [1:0] TXQ_RESET      = 2'h2;
	localparam logic [1:0] TXQ_RESERVED   = 2'h3;
	localparam logic [2:0] TXSRC_OFF      = 3'h0;
	localparam logic [2:0] TXSRC_THROUGH  = 3'h1;
	localparam logic [2:0] TXSRC_NORMAL   = 3'h5;
	localparam logic [1:0] USER_RESERVED  = 2'h2;
	localparam logic [1:0] RX_SEL_LINE1   = 2'h0;
	localparam logic [3:0] CLK_LAST_CODE  = 4'h9;
	localparam logic [3:0] CLK_FIXED_BASE = 4'h5;
	localparam logic [2:0] GAIN_RESERVED  = 3'h7;
	localparam logic [2:0] CLK_RECOVERED  = 3'h0;

	// Bus handshake states, Gray coded
	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_type;

	// Byte address of a register index
	function automatic logic [25:0] byte_addr(input logic [23:0] index);
		return {index, 2'b00};
	endfunction

	// Samples needed before the full indication rises
	function automatic logic [2:0] full_level(input logic [1:0] code);
		case (code)
			2'h0:    return 3'h1;
			2'h1:    return 3'h2;
			2'h2:    return 3'h3;
			default: return 3'h6;
		endcase
	endfunction

	// Byte-lane merge of a write into a 24-bit register
	function automatic logic [23:0] lane_merge(input logic [23:0] old, input logic [31:0] data,
		input logic [3:0] lanes);
		logic [23:0] result;
		result = old;
		for (int i = 0; i < 3; i++) begin
			if (lanes[i]) begin
				result[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return result;
	endfunction

endpackage

// [hw/spdif_control_config_regs.sv]
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
module spdif_control_config_regs import spdif_config_pkg::*; #(
	parameter int SAMPLE_WIDTH = 24,
	parameter int QUEUE_DEPTH  = 6
) (
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	// Avalon-MM slave
	input  wire logic [25:0]             address,
	input  wire logic                    read,
	input  wire logic                    write,
	input  wire logic [31:0]             writedata,
	input  wire logic [3:0]              byteenable,
	output      logic [31:0]             readdata,
	output      logic                    waitrequest,
	// Receiver side
	input  wire logic                    rx_sample_valid,
	input  wire logic [SAMPLE_WIDTH-1:0] rx_sample,
	input  wire logic                    dpll_lock_pin,
	input  wire logic                    line_input_one,
	// Transmitter side
	input  wire logic                    tx_bitstream,
	input  wire logic                    tx_queue_empty,
	output      logic                    line_out,
	output      logic                    tx_validity_bit,
	output      logic                    tx_send_zero,
	output      logic                    tx_queue_reset,
	output      logic [1:0]              user_bits_source,
	// Resync, clocking and loop controls
	output      logic                    rx_auto_resync_en,
	output      logic                    tx_auto_resync_en,
	output      logic                    subcode_mode,
	output      logic [2:0]              tx_clock_select,
	output      logic [2:0]              loop_gain_select,
	// Requests and interrupt
	output      logic                    rx_full,
	output      logic                    dma_rx_request,
	output      logic                    dma_tx_request,
	output      logic                    irq
);

	localparam int CW = $clog2(QUEUE_DEPTH + 1);

	// ************************************************************
	// Declarations
	// ************************************************************
	bus_state_type         bus_state_reg;
	bus_state_type         bus_state_next;
	logic [23:0]           config_reg;
	logic [23:0]           cd_text_reg;
	logic [23:0]           phase_reg;
	logic [IRQ_WIDTH-1:0]  int_stat_reg;
	logic [IRQ_WIDTH-1:0]  int_mask_reg;
	logic [IRQ_WIDTH-1:0]  stat_taken_reg;
	logic [IRQ_WIDTH-1:0]  events;
	logic [23:0]           read_word;
	logic                  accept;
	logic                  rd_data_hit;
	logic                  sync_lock;
	logic                  sync_line;
	logic                  lock_prev_reg;
	logic                  full_prev_reg;
	logic                  empty_prev_reg;
	logic [SAMPLE_WIDTH-1:0] queue_head;
	logic [CW-1:0]         queue_count;
	logic [23:0]           cfg_wr;
	logic [23:0]           phase_wr;

	if (SAMPLE_WIDTH < 1 || SAMPLE_WIDTH > 24) begin : width_check
		$error("sample width must fit a 24-bit register");
	end

	// ************************************************************
	// Pin synchronisers
	// ************************************************************

	// Lock pin and line input arrive from outside this clock
	pin_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.clock     (clock),
		.reset_n   (reset_n),
		.pin_in    ({dpll_lock_pin, line_input_one}),
		.level_out ({sync_lock, sync_line})
	);

	// ************************************************************
	// Bus handshake
	// ************************************************************

	// One wait cycle, then the answer; unmapped addresses answer too
	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_IDLE: begin
				if (read || write) begin
					bus_state_next = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				bus_state_next = BUS_IDLE;
			end
			default: begin
				bus_state_next = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			bus_state_reg <= BUS_IDLE;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	assign waitrequest = (read || write) && (bus_state_reg != BUS_ANSWER);
	assign accept      = (read || write) && (bus_state_reg == BUS_ANSWER);
	assign rd_data_hit = (address == byte_addr(RX_LEFT_INDEX)) || (address == byte_addr(RX_RIGHT_INDEX));

	// ************************************************************
	// Read path
	// ************************************************************

	// Register image for the addressed word
	always_comb begin
		read_word = 24'h00_0000;
		if (address == byte_addr(CONFIG_INDEX)) begin
			read_word = config_reg;
		end else if (address == byte_addr(CD_TEXT_INDEX)) begin
			read_word = cd_text_reg & CD_TEXT_WMASK;
		end else if (address == byte_addr(PHASE_INDEX)) begin
			read_word = phase_reg & PHASE_WMASK;
			read_word[LOCK_BIT] = sync_lock;
		end else if (rd_data_hit) begin
			if (!config_reg[RD_ZERO_BIT]) begin
				read_word[SAMPLE_WIDTH-1:0] = queue_head;
			end
		end else if (address == byte_addr(INT_STAT_INDEX)) begin
			read_word[IRQ_WIDTH-1:0] = int_stat_reg;
		end else if (address == byte_addr(INT_MASK_INDEX)) begin
			read_word[IRQ_WIDTH-1:0] = int_mask_reg;
		end
	end

	// Read data settle in the wait cycle so they stand at the answer edge
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			readdata       <= 32'h0000_0000;
			stat_taken_reg <= '0;
		end else if (read && bus_state_reg == BUS_IDLE) begin
			readdata       <= {8'h00, read_word};
			stat_taken_reg <= (address == byte_addr(INT_STAT_INDEX)) ? int_stat_reg : '0;
		end
	end

	// ************************************************************
	// Write path
	// ************************************************************

	// Merged write images, reserved bits dropped
	assign cfg_wr   = lane_merge(config_reg, writedata, byteenable) & CONFIG_WMASK;
	assign phase_wr = lane_merge(phase_reg, writedata, byteenable) & PHASE_WMASK;

	// Main configuration; a reserved code keeps the field as it was
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			config_reg <= CONFIG_RESET;
		end else if (accept && write && address == byte_addr(CONFIG_INDEX)) begin
			config_reg <= cfg_wr;
			config_reg[RX_SEL_LSB +: 2] <= RX_SEL_LINE1;
			if (cfg_wr[TXQ_CTRL_LSB +: 2] == TXQ_RESERVED) begin
				config_reg[TXQ_CTRL_LSB +: 2] <= config_reg[TXQ_CTRL_LSB +: 2];
			end
			if (cfg_wr[TX_SRC_LSB +: 3] != TXSRC_OFF && cfg_wr[TX_SRC_LSB +: 3] != TXSRC_THROUGH &&
				cfg_wr[TX_SRC_LSB +: 3] != TXSRC_NORMAL) begin
				config_reg[TX_SRC_LSB +: 3] <= config_reg[TX_SRC_LSB +: 3];
			end
			if (cfg_wr[USER_SRC_LSB +: 2] == USER_RESERVED) begin
				config_reg[USER_SRC_LSB +: 2] <= config_reg[USER_SRC_LSB +: 2];
			end
		end
	end

	// Subcode mode register keeps only its one live bit
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cd_text_reg <= CD_TEXT_RESET;
		end else if (accept && write && address == byte_addr(CD_TEXT_INDEX)) begin
			cd_text_reg <= lane_merge(cd_text_reg, writedata, byteenable) & CD_TEXT_WMASK;
		end
	end

	// Phase register; lock bit is never stored, so writes cannot touch it
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			phase_reg <= PHASE_RESET;
		end else if (accept && write && address == byte_addr(PHASE_INDEX)) begin
			phase_reg <= phase_wr;
			if (phase_wr[CLK_SRC_LSB +: 4] > CLK_LAST_CODE) begin
				phase_reg[CLK_SRC_LSB +: 4] <= phase_reg[CLK_SRC_LSB +: 4];
			end
			if (phase_wr[GAIN_LSB +: 3] == GAIN_RESERVED) begin
				phase_reg[GAIN_LSB +: 3] <= phase_reg[GAIN_LSB +: 3];
			end
		end
	end

	// ************************************************************
	// Receive queue
	// ************************************************************

	// Each accepted data read pops one sample, even when forced to zero, except while the queue reset bit holds keep_one
	rx_sample_queue #(
		.WIDTH (SAMPLE_WIDTH),
		.DEPTH (QUEUE_DEPTH)
	) u_rx_queue (
		.clock      (clock),
		.reset_n    (reset_n),
		.disable_in (config_reg[RXQ_DIS_BIT]),
		.keep_one   (config_reg[RXQ_RST_BIT]),
		.push       (rx_sample_valid),
		.push_data  (rx_sample),
		.pop        (accept && read && rd_data_hit),
		.head_reg   (queue_head),
		.count_reg  (queue_count)
	);

	// ************************************************************
	// Control outputs
	// ************************************************************

	// Full level and DMA requests are registered to keep them glitch free
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_full        <= 1'b0;
			dma_rx_request <= 1'b0;
			dma_tx_request <= 1'b0;
		end else begin
			rx_full        <= queue_count >= CW'(full_level(config_reg[RX_THR_LSB +: 2]));
			dma_rx_request <= config_reg[DMA_RX_BIT] &&
				(queue_count >= CW'(full_level(config_reg[RX_THR_LSB +: 2])));
			dma_tx_request <= config_reg[DMA_TX_BIT] && tx_queue_empty;
		end
	end

	// Transmit path selection; reserved codes never reach the register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			line_out <= 1'b0;
		end else begin
			case (config_reg[TX_SRC_LSB +: 3])
				TXSRC_THROUGH: line_out <= sync_line;
				TXSRC_NORMAL:  line_out <= tx_bitstream && (config_reg[TXQ_CTRL_LSB +: 2] != TXQ_ZERO);
				default:       line_out <= 1'b0;
			endcase
		end
	end

	// Clock selection falls back to the fixed source while unlocked
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tx_clock_select <= CLK_RECOVERED;
		end else if (phase_reg[CLK_SRC_LSB +: 4] >= CLK_FIXED_BASE) begin
			tx_clock_select <= 3'(phase_reg[CLK_SRC_LSB +: 4] - CLK_FIXED_BASE) + 3'h1;
		end else if (sync_lock) begin
			tx_clock_select <= CLK_RECOVERED;
		end else begin
			tx_clock_select <= phase_reg[CLK_SRC_LSB +: 3] + 3'h1;
		end
	end

	// Straight decodes of stored fields
	assign tx_validity_bit   = !config_reg[VALIDITY_BIT];
	assign tx_send_zero      = config_reg[TXQ_CTRL_LSB +: 2] == TXQ_ZERO;
	assign tx_queue_reset    = config_reg[TXQ_CTRL_LSB +: 2] == TXQ_RESET;
	assign rx_auto_resync_en = config_reg[RX_RESYNC_BIT];
	assign tx_auto_resync_en = config_reg[TX_RESYNC_BIT];
	assign user_bits_source  = config_reg[USER_SRC_LSB +: 2];
	assign subcode_mode      = cd_text_reg[SUBCODE_BIT];
	assign loop_gain_select  = phase_reg[GAIN_LSB +: 3];

	// ************************************************************
	// Interrupts
	// ************************************************************

	// Previous levels for edge detection
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			lock_prev_reg  <= 1'b0;
			full_prev_reg  <= 1'b0;
			empty_prev_reg <= 1'b0;
		end else begin
			lock_prev_reg  <= sync_lock;
			full_prev_reg  <= rx_full;
			empty_prev_reg <= tx_queue_empty;
		end
	end

	always_comb begin
		events = '0;
		events[IRQ_RX_FULL]   = rx_full && !full_prev_reg;
		events[IRQ_TX_EMPTY]  = tx_queue_empty && !empty_prev_reg;
		events[IRQ_LOCK_GAIN] = sync_lock && !lock_prev_reg;
		events[IRQ_LOCK_LOSS] = !sync_lock && lock_prev_reg;
	end

	// Read clears only the bits it returned; a new event wins over the clear
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			int_stat_reg <= '0;
		end else if (accept && read && address == byte_addr(INT_STAT_INDEX)) begin
			int_stat_reg <= (int_stat_reg & ~stat_taken_reg) | events;
		end else begin
			int_stat_reg <= int_stat_reg | events;
		end
	end

	// Mask register, one bit per status bit
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			int_mask_reg <= '0;
		end else if (accept && write && address == byte_addr(INT_MASK_INDEX) && byteenable[0]) begin
			int_mask_reg <= writedata[IRQ_WIDTH-1:0];
		end
	end

	assign irq = |(int_stat_reg & int_mask_reg);

endmodule

// [testbench/spdif_control_config_regs_tb.sv]
`timescale 1ns/10ps
module spdif_control_config_regs_tb import spdif_config_pkg::*;;
	logic        clock, reset_n, read, write, rx_sample_valid, dpll_lock_pin, line_input_one, tx_bitstream;
	logic        tx_queue_empty, waitrequest, line_out, tx_validity_bit, tx_send_zero, tx_queue_reset;
	logic        rx_auto_resync_en, tx_auto_resync_en, subcode_mode, rx_full, dma_rx_request, dma_tx_request, irq;
	logic [25:0] address;
	logic [31:0] writedata, readdata, q;
	logic [3:0]  byteenable;
	logic [23:0] rx_sample;
	logic [1:0]  user_bits_source;
	logic [2:0]  tx_clock_select, loop_gain_select;
	int          errors, n_compared;
	int          lv[4] = '{1, 2, 3, 6};
	localparam logic [25:0] CFG = {CONFIG_INDEX, 2'b00};
	localparam logic [25:0] CDT = {CD_TEXT_INDEX, 2'b00};
	localparam logic [25:0] PHS = {PHASE_INDEX, 2'b00};
	localparam logic [25:0] RXL = {RX_LEFT_INDEX, 2'b00};
	localparam logic [25:0] RXR = {RX_RIGHT_INDEX, 2'b00};
	localparam logic [25:0] IST = {INT_STAT_INDEX, 2'b00};
	localparam logic [25:0] IMK = {INT_MASK_INDEX, 2'b00};

	spdif_control_config_regs dut (.clock(clock), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .rx_sample_valid(rx_sample_valid), .rx_sample(rx_sample),
		.dpll_lock_pin(dpll_lock_pin), .line_input_one(line_input_one), .tx_bitstream(tx_bitstream),
		.tx_queue_empty(tx_queue_empty), .line_out(line_out), .tx_validity_bit(tx_validity_bit),
		.tx_send_zero(tx_send_zero), .tx_queue_reset(tx_queue_reset), .user_bits_source(user_bits_source),
		.rx_auto_resync_en(rx_auto_resync_en), .tx_auto_resync_en(tx_auto_resync_en),
		.subcode_mode(subcode_mode), .tx_clock_select(tx_clock_select), .loop_gain_select(loop_gain_select),
		.rx_full(rx_full), .dma_rx_request(dma_rx_request), .dma_tx_request(dma_tx_request), .irq(irq));

	// ****************
	// Clock, checks and bus tasks
	// ****************
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Request held until waitrequest is seen low; a bounded wait avoids a silent hang
	task automatic bus(input logic [25:0] a, input logic w, input logic [23:0] d);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= {8'h00, d};
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n == 50) errors++;
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [25:0] a, input logic [23:0] d);
		bus(a, 1'b1, d);
		wt(3);
	endtask

	task automatic rdc(input logic [25:0] a, input logic [31:0] e);
		bus(a, 1'b0, 24'h00_0000);
		chk(q, e);
	endtask

	task automatic push(input logic [23:0] d);
		@(posedge clock);
		rx_sample_valid <= 1'b1;
		rx_sample <= d;
		@(posedge clock);
		rx_sample_valid <= 1'b0;
		wt(3);
	endtask

	task automatic end_sim;
		if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		end_sim();
	end

	// ****************
	// Test sequence
	// ****************
	initial begin
		{reset_n, read, write, rx_sample_valid, dpll_lock_pin, tx_queue_empty} = 6'h00;
		{line_input_one, tx_bitstream} = 2'b10;
		{address, writedata, rx_sample} = '0;
		byteenable = 4'hF;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		wt(1);
		chk(tx_validity_bit, 1);
		rdc(CFG, 32'h0000_0400);
		rdc(CDT, 0);
		rdc(PHS, 0);
		rdc(26'h3FF_FD8C, 0);
		wr(CFG, 24'hFF_FFFF);
		chk(tx_validity_bit, 0);
		chk(rx_auto_resync_en, 1);
		chk(tx_auto_resync_en, 1);
		rdc(CFG, 32'h00FE_0723);
		wr(CFG, 24'h00_0000);
		chk(rx_auto_resync_en, 0);
		chk(tx_auto_resync_en, 0);
		chk(tx_validity_bit, 1);
		for (int c = 0; c < 4; c++) begin
			wr(CFG, 24'(c) << 10);
			chk(tx_send_zero, c == 0);
			chk(tx_queue_reset, c >= 2);
		end
		for (int u = 0; u < 4; u++) begin
			wr(CFG, 24'h00_0400 | 24'(u));
			chk(user_bits_source, u == 2 ? 1 : u);
		end
		wr(CFG, 24'h00_0404);
		chk(line_out, 1);
		wr(CFG, 24'h00_0400);
		chk(line_out, 0);
		@(posedge clock);
		tx_bitstream <= 1'b1;
		tx_queue_empty <= 1'b1;
		wr(CFG, 24'h00_0414);
		chk(line_out, 1);
		wr(CFG, 24'h00_0408);
		chk(line_out, 1);
		wr(CFG, 24'h00_0014);
		chk(line_out, 0);
		wr(CFG, 24'h00_0500);
		chk(dma_tx_request, 1);
		wr(CFG, 24'h00_0400);
		chk(dma_tx_request, 0);
		// Each threshold filled to one short, then to the level, then drained
		for (int k = 0; k < 4; k++) begin
			wr(CFG, 24'h00_0600 | (24'(k) << 19));
			for (int i = 0; i < lv[k]; i++) begin
				chk(rx_full, 0);
				push(24'h00_A000 + 24'(i));
			end
			chk(rx_full, 1);
			chk(dma_rx_request, 1);
			for (int i = 0; i < lv[k]; i++) rdc(i[0] ? RXR : RXL, 32'h0000_A000 + 32'(i));
			wt(3);
			chk(rx_full, 0);
		end
		wr(CFG, 24'h80_0400);
		push(24'h12_3456);
		chk(dma_rx_request, 0);
		rdc(RXL, 0);
		wt(3);
		chk(rx_full, 0);
		wr(CFG, 24'h40_0400);
		push(24'h00_0055);
		chk(rx_full, 0);
		wr(CFG, 24'h08_0400);
		for (int i = 0; i < 3; i++) push(24'h00_0077);
		wr(CFG, 24'h28_0400);
		chk(rx_full, 0);
		wr(CFG, 24'h00_0400);
		chk(rx_full, 1);
		bus(RXL, 1'b0, 24'h00_0000);
		wt(3);
		chk(rx_full, 0);
		wr(CDT, 24'hFF_FFFF);
		chk(subcode_mode, 1);
		rdc(CDT, 2);
		wr(PHS, 24'hFF_FFFF);
		rdc(PHS, 0);
		wr(PHS, 24'h00_04B0);
		chk(tx_clock_select, 5);
		chk(loop_gain_select, 6);
		wr(PHS, 24'h00_0080);
		chk(tx_clock_select, 2);
		@(posedge clock);
		dpll_lock_pin <= 1'b1;
		wt(6);
		chk(tx_clock_select, 0);
		rdc(PHS, 32'h0000_00C0);
		// Interrupt: cleared, raised while masked, unmasked, then read-cleared
		@(posedge clock);
		tx_queue_empty <= 1'b0;
		bus(IST, 1'b0, 24'h00_0000);
		@(posedge clock);
		tx_queue_empty <= 1'b1;
		wt(3);
		chk(irq, 0);
		wr(IMK, 24'h00_0002);
		chk(irq, 1);
		rdc(IST, 32'h0000_0002);
		wt(2);
		chk(irq, 0);
		end_sim();
	end
endmodule

// [testbench/spdif_regs_props.sv]
`timescale 1ns/10ps
module spdif_regs_props import spdif_config_pkg::*; (
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset_n,
	// Register bus
	input wire logic [25:0] address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// Block side
	input wire logic        tx_queue_empty,
	input wire logic        line_out,
	input wire logic        tx_validity_bit,
	input wire logic        tx_send_zero,
	input wire logic        subcode_mode,
	input wire logic        rx_full,
	input wire logic        dma_rx_request,
	input wire logic        dma_tx_request
);
	// ****************
	// Accepted accesses
	// ****************
	logic cfg_w, cd_w, cd_r, ph_r;
	assign cfg_w = write && !waitrequest && address == {CONFIG_INDEX, 2'b00};
	assign cd_w = write && !waitrequest && address == {CD_TEXT_INDEX, 2'b00};
	assign cd_r = read && !waitrequest && address == {CD_TEXT_INDEX, 2'b00};
	assign ph_r = read && !waitrequest && address == {PHASE_INDEX, 2'b00};

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Write-driven outputs are tied to the write that was accepted, not to the raw bus
	chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus wait longer than one cycle");
	chk_validity_flag: assert property (cfg_w && byteenable[0] |=> tx_validity_bit == !$past(writedata[5]))
		else $error("validity flag wrong");
	chk_tx_zero: assert property (cfg_w && byteenable[1] && writedata[11:10] != 2'h3 |=>
		tx_send_zero == ($past(writedata[11:10]) == 2'h0)) else $error("send zero wrong");
	chk_subcode_mode: assert property (cd_w && byteenable[0] |=> subcode_mode == $past(writedata[1]))
		else $error("subcode mode wrong");
	chk_output_off: assert property (cfg_w && byteenable[0] && writedata[4:2] == 3'h0 |-> ##2 !line_out)
		else $error("line output not off");
	chk_dma_tx_cause: assert property (dma_tx_request |-> $past(tx_queue_empty))
		else $error("transmit request without empty");
	chk_dma_rx_cause: assert property (dma_rx_request |-> rx_full)
		else $error("receive request without full");
	chk_cd_zero_bits: assert property (cd_r |-> readdata[23:15] == 9'h000 && readdata[7:3] == 5'h00)
		else $error("cd text reserved bits set");
	chk_phase_zero_bits: assert property (ph_r |-> readdata[23:11] == 13'h0000 && readdata[2:0] == 3'h0)
		else $error("phase reserved bits set");

	// Main scenarios reached
	cover property (cfg_w);
	cover property (dma_rx_request);
	cover property ($rose(rx_full));
endmodule

bind spdif_control_config_regs spdif_regs_props u_props (.clock(clock), .reset_n(reset_n), .address(address),
	.read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .tx_queue_empty(tx_queue_empty), .line_out(line_out),
	.tx_validity_bit(tx_validity_bit), .tx_send_zero(tx_send_zero), .subcode_mode(subcode_mode),
	.rx_full(rx_full), .dma_rx_request(dma_rx_request), .dma_tx_request(dma_tx_request));
